// ===== hdl/fcp_pkg.sv
package fcp_pkg;

  // ***********************************************************************
  // register map (byte offsets, one aligned word each)
  // ***********************************************************************
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_TRAVEL = 8'h04;
  localparam logic [7:0] REG_TXDATA = 8'h08;
  localparam logic [7:0] REG_STAT   = 8'h0c;

  localparam int CTRL_EDIT_LSB = 0;
  localparam int CTRL_RATE_LSB = 2;
  localparam int CTRL_LINE_LSB = 5;
  localparam int TX_CTX_LSB    = 8;
  localparam int STAT_OVR_BIT  = 1;

  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // ***********************************************************************
  // widths
  // ***********************************************************************
  localparam int TRAVEL_W = 12;
  localparam int FACTOR_W = 11;
  localparam int COUNT_W  = 13;
  localparam int PROD_W   = 24;
  localparam int DIV_W    = 20;

  // ***********************************************************************
  // modes and codes
  // ***********************************************************************
  typedef enum logic [1:0] {
    format_edit_mode  = 2'b00,
    typing_mode       = 2'b01,
    conversation_mode = 2'b10,
    edit_spare        = 2'b11
  } fcp_edit_t;

  typedef enum logic [1:0] {
    line_sync8   = 2'b00,
    line_async10 = 2'b01,
    line_async11 = 2'b10,
    line_spare   = 2'b11
  } fcp_line_t;

  typedef enum logic [2:0] {
    rate_2400 = 3'b000,
    rate_2000 = 3'b001,
    rate_1800 = 3'b010,
    rate_1200 = 3'b011,
    rate_1000 = 3'b100,
    rate_110  = 3'b101,
    rate_sp6  = 3'b110,
    rate_sp7  = 3'b111
  } fcp_rate_t;

  // context of the character just written, as software judges it
  typedef enum logic [3:0] {
    ctx_plain          = 4'h0,
    ctx_backspace      = 4'h1,
    ctx_screen_clear   = 4'h2,
    ctx_field_open     = 4'h3,
    ctx_field_close    = 4'h4,
    ctx_cursor_return  = 4'h5,
    ctx_entry_at_close = 4'h6,
    ctx_bs_after_open  = 4'h7
  } fcp_ctx_t;

  localparam logic [7:0] NULL_CODE = 8'h00;

  // ***********************************************************************
  // timing and rate factors (factor held in thousandths)
  // ***********************************************************************
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int unsigned BAUD_2400 = 2400;
  localparam int unsigned BAUD_2000 = 2000;
  localparam int unsigned BAUD_1800 = 1800;
  localparam int unsigned BAUD_1200 = 1200;
  localparam int unsigned BAUD_1000 = 1000;
  localparam int unsigned BAUD_110  = 110;

  localparam int unsigned FACTOR_SCALE = 1000;
  localparam int unsigned POS_DIVISOR  = 260;
  localparam int unsigned CLEAR_MULT   = 5;

  localparam logic [10:0] F_NA      = 11'h000;
  localparam logic [10:0] F_2400_S8 = 11'd1670;
  localparam logic [10:0] F_2400_10 = 11'd1330;
  localparam logic [10:0] F_2400_11 = 11'd1210;
  localparam logic [10:0] F_2000_S8 = 11'd1390;
  localparam logic [10:0] F_2000_10 = 11'd1110;
  localparam logic [10:0] F_2000_11 = 11'd1010;
  localparam logic [10:0] F_1800_10 = 11'd1000;
  localparam logic [10:0] F_1800_11 = 11'd908;
  localparam logic [10:0] F_1200_10 = 11'd666;
  localparam logic [10:0] F_1200_11 = 11'd605;
  localparam logic [10:0] F_1000_10 = 11'd555;
  localparam logic [10:0] F_1000_11 = 11'd505;
  localparam logic [10:0] F_110_10  = 11'd61;
  localparam logic [10:0] F_110_11  = 11'd56;

  localparam logic [3:0] BITS_SYNC8   = 4'd8;
  localparam logic [3:0] BITS_ASYNC10 = 4'd10;
  localparam logic [3:0] BITS_ASYNC11 = 4'd11;

endpackage

// ===== hdl/fcp_ser_if.sv
interface fcp_ser_if;
  logic [7:0]                   data;
  logic                         valid;
  logic                         ready;
  fcp_pkg::fcp_line_t           line;
  logic [fcp_pkg::DIV_W-1:0]    div;

  modport ctl (output data, valid, line, div, input ready);
  modport ser (input data, valid, line, div, output ready);
endinterface

// ===== hdl/fcp_line_tx.sv
module fcp_line_tx (
  input  wire logic clk_i,      // system clock
  input  wire logic nrst_i,     // async reset, active low
  fcp_ser_if.ser    sif,        // characters to send
  output logic      line_txd_o, // serial line, idles at mark
  output logic      line_clk_o  // bit clock, sync mode only
);

  logic [10:0]               shreg;
  logic [3:0]                bits_left;
  logic [fcp_pkg::DIV_W-1:0] div_cnt;
  logic                      sync_q;

  assign sif.ready = (bits_left == 4'h0);

  // ***********************************************************************
  // frame shifter, lsb first
  // ***********************************************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shreg      <= 11'h7ff;
      bits_left  <= 4'h0;
      div_cnt    <= '0;
      sync_q     <= 1'b0;
      line_txd_o <= 1'b1;
    end else if (sif.valid && sif.ready) begin
      div_cnt <= sif.div;
      sync_q  <= (sif.line == fcp_pkg::line_sync8);
      if (sif.line == fcp_pkg::line_sync8) begin
        shreg      <= {3'h7, sif.data};
        bits_left  <= fcp_pkg::BITS_SYNC8;
        line_txd_o <= sif.data[0];
      end else begin
        shreg      <= {2'h3, sif.data, 1'b0};
        bits_left  <= (sif.line == fcp_pkg::line_async11) ?
                      fcp_pkg::BITS_ASYNC11 : fcp_pkg::BITS_ASYNC10;
        line_txd_o <= 1'b0;
      end
    end else if (bits_left != 4'h0) begin
      if (div_cnt <= 1) begin
        div_cnt    <= sif.div;
        shreg      <= {1'b1, shreg[10:1]};
        bits_left  <= bits_left - 4'h1;
        line_txd_o <= (bits_left == 4'h1) ? 1'b1 : shreg[1];
      end else begin
        div_cnt <= div_cnt - 1'b1;
      end
    end
  end

  // bit clock high during the first half of each sync bit
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      line_clk_o <= 1'b0;
    end else begin
      line_clk_o <= sync_q && (bits_left != 4'h0) &&
                    (div_cnt > (sif.div >> 1));
    end
  end

endmodule

// ===== hdl/fcp_fill_calc.sv
module fcp_fill_calc (
  input  wire fcp_pkg::fcp_edit_t          edit_i,   // editing mode
  input  wire fcp_pkg::fcp_line_t          line_i,   // line mode
  input  wire fcp_pkg::fcp_rate_t          rate_i,   // line rate
  input  wire fcp_pkg::fcp_ctx_t           ctx_i,    // character context
  input  wire logic [fcp_pkg::TRAVEL_W-1:0] travel_i, // cursor travel
  output logic [fcp_pkg::FACTOR_W-1:0]     factor_o, // factor, thousandths
  output logic [fcp_pkg::COUNT_W-1:0]      count_o,  // nulls to append
  output logic                             na_o      // no factor exists
);

  localparam logic [23:0] SCALE   = 24'(fcp_pkg::FACTOR_SCALE);
  localparam logic [23:0] POS_DEN =
    24'(fcp_pkg::FACTOR_SCALE * fcp_pkg::POS_DIVISOR);

  logic [fcp_pkg::TRAVEL_W-1:0] mult;
  logic                         per_pos;
  logic [fcp_pkg::PROD_W-1:0]   prod;

  // ***********************************************************************
  // rate factor table
  // ***********************************************************************
  always_comb begin
    factor_o = fcp_pkg::F_NA;
    case (rate_i)
      fcp_pkg::rate_2400: factor_o = (line_i == fcp_pkg::line_sync8) ?
        fcp_pkg::F_2400_S8 : (line_i == fcp_pkg::line_async10) ?
        fcp_pkg::F_2400_10 : fcp_pkg::F_2400_11;
      fcp_pkg::rate_2000: factor_o = (line_i == fcp_pkg::line_sync8) ?
        fcp_pkg::F_2000_S8 : (line_i == fcp_pkg::line_async10) ?
        fcp_pkg::F_2000_10 : fcp_pkg::F_2000_11;
      fcp_pkg::rate_1800: factor_o = (line_i == fcp_pkg::line_async10) ?
        fcp_pkg::F_1800_10 : fcp_pkg::F_1800_11;
      fcp_pkg::rate_1200: factor_o = (line_i == fcp_pkg::line_async10) ?
        fcp_pkg::F_1200_10 : fcp_pkg::F_1200_11;
      fcp_pkg::rate_1000: factor_o = (line_i == fcp_pkg::line_async10) ?
        fcp_pkg::F_1000_10 : fcp_pkg::F_1000_11;
      fcp_pkg::rate_110: factor_o = (line_i == fcp_pkg::line_async10) ?
        fcp_pkg::F_110_10 : fcp_pkg::F_110_11;
      default: factor_o = fcp_pkg::F_NA;
    endcase
    // sync lines exist only at the two top rates
    if (line_i == fcp_pkg::line_spare ||
        (line_i == fcp_pkg::line_sync8 && rate_i != fcp_pkg::rate_2400 &&
         rate_i != fcp_pkg::rate_2000)) begin
      factor_o = fcp_pkg::F_NA;
    end
  end

  assign na_o = (factor_o == fcp_pkg::F_NA);

  // ***********************************************************************
  // multiple of the factor per mode and context
  // ***********************************************************************
  always_comb begin
    mult    = '0;
    per_pos = 1'b0;
    case (edit_i)
      fcp_pkg::format_edit_mode: begin
        if (ctx_i == fcp_pkg::ctx_backspace ||
            ctx_i == fcp_pkg::ctx_bs_after_open) mult = 12'd1;
      end
      fcp_pkg::typing_mode: begin
        case (ctx_i)
          fcp_pkg::ctx_screen_clear: mult = 12'(fcp_pkg::CLEAR_MULT);
          fcp_pkg::ctx_backspace:    mult = 12'd1;
          fcp_pkg::ctx_bs_after_open,
          fcp_pkg::ctx_field_open:   mult = travel_i;
          fcp_pkg::ctx_field_close,
          fcp_pkg::ctx_cursor_return,
          fcp_pkg::ctx_entry_at_close: begin
            mult    = travel_i;
            per_pos = 1'b1;
          end
          default: mult = '0;
        endcase
      end
      fcp_pkg::conversation_mode: begin
        if (ctx_i == fcp_pkg::ctx_backspace ||
            ctx_i == fcp_pkg::ctx_bs_after_open) mult = 12'd1;
        if (ctx_i == fcp_pkg::ctx_cursor_return) begin
          mult    = travel_i;
          per_pos = 1'b1;
        end
      end
      default: mult = '0;
    endcase
  end

  // only the final product is rounded down
  assign prod    = 24'(mult) * 24'(factor_o);
  assign count_o = per_pos ? 13'(prod / POS_DEN) : 13'(prod / SCALE);
endmodule

// ===== hdl/fcp_host.sv
module fcp_host #(
  parameter int unsigned CLK_HZ = fcp_pkg::CLK_HZ // clock rate in hertz
) (
  input  wire logic        clk_i,       // system clock
  input  wire logic        nrst_i,      // async reset, active low
  input  wire logic        hsel_i,      // slave select
  input  wire logic [31:0] haddr_i,     // byte address
  input  wire logic [1:0]  htrans_i,    // transfer type
  input  wire logic        hwrite_i,    // write when high
  input  wire logic [2:0]  hsize_i,     // transfer size
  input  wire logic [31:0] hwdata_i,    // write data
  input  wire logic        hready_i,    // bus ready
  output logic             hreadyout_o, // slave ready
  output logic             hresp_o,     // response, always okay
  output logic [31:0]      hrdata_o,    // read data
  output logic             line_txd_o,  // serial line to terminal
  output logic             line_clk_o   // bit clock, sync mode
);

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_char = 2'b01,
    st_fill = 2'b10
  } fcp_state_t;

  fcp_ser_if sif ();

  logic                         dp_act;
  logic                         dp_wr;
  logic [7:0]                   dp_addr;
  fcp_pkg::fcp_edit_t           edit_q;
  fcp_pkg::fcp_rate_t           rate_q;
  fcp_pkg::fcp_line_t           line_q;
  logic [fcp_pkg::TRAVEL_W-1:0] travel_q;
  logic [7:0]                   char_q;
  logic [fcp_pkg::COUNT_W-1:0]  remain_q;
  fcp_state_t                   state;
  logic                         ovr_q;
  logic                         cfg_q;
  logic [fcp_pkg::FACTOR_W-1:0] factor;
  logic [fcp_pkg::COUNT_W-1:0]  fill_cnt;
  logic                         fill_na;
  logic                         wr_ctrl;
  logic                         wr_travel;
  logic                         wr_tx;
  logic                         wr_stat;
  logic                         accept;
  logic                         hs;
  logic                         busy;
  logic [31:0]                  next_rdata;
  logic [fcp_pkg::COUNT_W-1:0]  sent_cnt;
  logic [fcp_pkg::COUNT_W-1:0]  loaded_cnt;

  // ***********************************************************************
  // bus slave: zero wait states, always okay
  // ***********************************************************************
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dp_act  <= 1'b0;
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
    end else if (hready_i) begin
      dp_act  <= hsel_i && htrans_i[1] && (hsize_i == 3'h2);
      dp_wr   <= hwrite_i;
      dp_addr <= (haddr_i[31:8] == 24'h0) ? haddr_i[7:0] : 8'hff;
    end
  end

  assign wr_ctrl   = dp_act && dp_wr && (dp_addr == fcp_pkg::REG_CTRL);
  assign wr_travel = dp_act && dp_wr && (dp_addr == fcp_pkg::REG_TRAVEL);
  assign wr_tx     = dp_act && dp_wr && (dp_addr == fcp_pkg::REG_TXDATA);
  assign wr_stat   = dp_act && dp_wr && (dp_addr == fcp_pkg::REG_STAT);
  assign busy      = (state != st_idle);

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (haddr_i[7:0])
      fcp_pkg::REG_CTRL:   next_rdata = {24'h0, 1'b0, line_q, rate_q, edit_q};
      fcp_pkg::REG_TRAVEL: next_rdata = {20'h0, travel_q};
      fcp_pkg::REG_TXDATA: next_rdata = {24'h0, char_q};
      fcp_pkg::REG_STAT:   next_rdata = {3'h0, remain_q, 13'h0,
                                         cfg_q, ovr_q, busy};
      default:             next_rdata = 32'h0000_0000;
    endcase
    if (haddr_i[31:8] != 24'h0) next_rdata = 32'h0000_0000;
  end

  // read data is a snapshot taken in the address phase
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hrdata_o <= fcp_pkg::RDATA_RESET;
    end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
      hrdata_o <= next_rdata;
    end
  end

  // ***********************************************************************
  // configuration registers
  // ***********************************************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      edit_q <= fcp_pkg::format_edit_mode;
      rate_q <= fcp_pkg::rate_2400;
      line_q <= fcp_pkg::line_async10;
    end else if (wr_ctrl) begin
      edit_q <= fcp_pkg::fcp_edit_t'(hwdata_i[fcp_pkg::CTRL_EDIT_LSB +: 2]);
      rate_q <= fcp_pkg::fcp_rate_t'(hwdata_i[fcp_pkg::CTRL_RATE_LSB +: 3]);
      line_q <= fcp_pkg::fcp_line_t'(hwdata_i[fcp_pkg::CTRL_LINE_LSB +: 2]);
    end
  end

  // travel estimate from software, worst case
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      travel_q <= '0;
    end else if (wr_travel) begin
      travel_q <= hwdata_i[fcp_pkg::TRAVEL_W-1:0];
    end
  end

  // ***********************************************************************
  // fill count for the character being written
  // ***********************************************************************
  fcp_fill_calc u_calc (
    .edit_i   (edit_q),
    .line_i   (line_q),
    .rate_i   (rate_q),
    .ctx_i    (fcp_pkg::fcp_ctx_t'(hwdata_i[fcp_pkg::TX_CTX_LSB +: 4])),
    .travel_i (travel_q),
    .factor_o (factor),
    .count_o  (fill_cnt),
    .na_o     (fill_na)
  );

  assign accept = wr_tx && !busy && !fill_na;

  // sticky flags, set wins over write-one-to-clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ovr_q <= 1'b0;
      cfg_q <= 1'b0;
    end else begin
      if (wr_tx && busy) ovr_q <= 1'b1;
      else if (wr_stat && hwdata_i[fcp_pkg::STAT_OVR_BIT]) ovr_q <= 1'b0;
      if (wr_tx && !busy && fill_na) cfg_q <= 1'b1;
      else if (wr_stat && hwdata_i[fcp_pkg::STAT_OVR_BIT + 1]) cfg_q <= 1'b0;
    end
  end

  // ***********************************************************************
  // character then its nulls
  // ***********************************************************************
  assign hs        = sif.valid && sif.ready;
  assign sif.valid = (state == st_char) || (state == st_fill);
  assign sif.data  = (state == st_fill) ? fcp_pkg::NULL_CODE : char_q;
  assign sif.line  = line_q;

  always_comb begin
    case (rate_q)
      fcp_pkg::rate_2400: sif.div = 20'(CLK_HZ / fcp_pkg::BAUD_2400);
      fcp_pkg::rate_2000: sif.div = 20'(CLK_HZ / fcp_pkg::BAUD_2000);
      fcp_pkg::rate_1800: sif.div = 20'(CLK_HZ / fcp_pkg::BAUD_1800);
      fcp_pkg::rate_1200: sif.div = 20'(CLK_HZ / fcp_pkg::BAUD_1200);
      fcp_pkg::rate_1000: sif.div = 20'(CLK_HZ / fcp_pkg::BAUD_1000);
      fcp_pkg::rate_110:  sif.div = 20'(CLK_HZ / fcp_pkg::BAUD_110);
      default:            sif.div = 20'(CLK_HZ / fcp_pkg::BAUD_2400);
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state    <= st_idle;
      char_q   <= 8'h00;
      remain_q <= '0;
    end else begin
      case (state)
        st_idle: begin
          if (accept) begin
            char_q   <= hwdata_i[7:0];
            remain_q <= fill_cnt;
            state    <= st_char;
          end
        end
        st_char: begin
          if (hs) state <= (remain_q == '0) ? st_idle : st_fill;
        end
        st_fill: begin
          if (hs) begin
            remain_q <= remain_q - 1'b1;
            if (remain_q == 13'h1) state <= st_idle;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  fcp_line_tx u_tx (
    .clk_i      (clk_i),
    .nrst_i     (nrst_i),
    .sif        (sif.ser),
    .line_txd_o (line_txd_o),
    .line_clk_o (line_clk_o)
  );

  // ***********************************************************************
  // checks
  // ***********************************************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sent_cnt   <= '0;
      loaded_cnt <= '0;
    end else if (accept) begin
      sent_cnt   <= '0;
      loaded_cnt <= fill_cnt;
    end else if (hs && state == st_fill) begin
      sent_cnt <= sent_cnt + 1'b1;
    end
  end

  null_fill_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state == st_fill) |-> (sif.valid && sif.data == 8'h00))
    else $error("fill character is not null");

  fill_after_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(state == st_fill) |-> ($past(state) == st_char))
    else $error("fill started without its control character");

  fill_total_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state == st_fill && hs && remain_q == 13'h1)
      |=> (state == st_idle && sent_cnt == loaded_cnt))
    else $error("null count sent differs from count loaded");

  fmt_back_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (accept && edit_q == fcp_pkg::format_edit_mode &&
     hwdata_i[11:8] == 4'h1) |=> (remain_q == 32'(factor) / 1000))
    else $error("format backspace fill wrong");

  tp_clear_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (accept && edit_q == fcp_pkg::typing_mode && hwdata_i[11:8] == 4'h2)
      |=> (remain_q == (5 * 32'(factor)) / 1000))
    else $error("screen clear fill wrong");

  tp_open_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (accept && edit_q == fcp_pkg::typing_mode && hwdata_i[11:8] == 4'h3)
      |=> (remain_q == (32'(travel_q) * 32'(factor)) / 1000))
    else $error("field open fill wrong");

  tp_close_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (accept && edit_q == fcp_pkg::typing_mode && hwdata_i[11:8] == 4'h4)
      |=> (remain_q == (32'(travel_q) * 32'(factor)) / 260000))
    else $error("field close fill wrong");

  ct_quiet_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (accept && edit_q == fcp_pkg::conversation_mode &&
     hwdata_i[11:8] == 4'h3) |=> (remain_q == 13'h0))
    else $error("conversation field open produced nulls");

  rate_factor_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rate_q == fcp_pkg::rate_2400 && line_q == fcp_pkg::line_sync8)
      |-> (factor == 11'd1670))
    else $error("sync 2400 factor wrong");

  slow_sync_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr_tx && !busy && line_q == fcp_pkg::line_sync8 &&
     rate_q == fcp_pkg::rate_1800) |=> (cfg_q && state == st_idle))
    else $error("sync line below 2000 baud not refused");

endmodule

// ===== verif/fcp_term_model.sv
module fcp_term_model (
  input  wire logic        clk_i,  // system clock
  input  wire logic        rxd_i,  // serial line from host
  input  wire logic [11:0] div_i,  // cycles per bit
  output logic [7:0]       last_o, // last non-null character
  output int               nnul_o  // nulls since that character
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] b;
  // ****************************************************
  // receiver: each frame is one memory cycle of work
  // ****************************************************
  initial begin
    nnul_o = 0;
    last_o = 8'h00;
    forever begin
      @(negedge rxd_i);
      repeat (div_i / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (div_i) @(posedge clk_i);
        b[i] = rxd_i;
      end
      repeat (div_i) @(posedge clk_i);
      if (b == 8'h00) nnul_o++;
      else begin
        last_o = b;
        nnul_o = 0;
      end
    end
  end
endmodule

// ===== verif/fcp_host_tb.sv
module fcp_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HZ = 24000;
  logic        clk_i, nrst_i, hsel, hwrite, hrdy, txd, lclk, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [11:0] div;
  logic [7:0]  last;
  int          nnul, errors, check_count, cyc;
  int fv[6] = '{1330, 1110, 1000, 666, 555, 61};
  int bd[6] = '{2400, 2000, 1800, 1200, 1000, 110};
  // ****************************************************
  // clock, design and terminal
  // ****************************************************
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  fcp_host #(.CLK_HZ(HZ)) dut (.clk_i(clk_i), .nrst_i(nrst_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
    .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata),
    .line_txd_o(txd), .line_clk_o(lclk));
  fcp_term_model term (.clk_i(clk_i), .rxd_i(txd), .div_i(div),
    .last_o(last), .nnul_o(nnul));
  // ****************************************************
  // tasks
  // ****************************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk_i);
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk_i); while (hrdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_i); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  task automatic send(input int m, r, l, t, ctx, ch, exp);
    div = 12'(HZ / bd[r]);
    xfer(1'b1, 8'h00, m | r << 2 | l << 5);
    xfer(1'b1, 8'h04, t);
    xfer(1'b1, 8'h08, ctx << 8 | ch);
    repeat (3000) begin
      xfer(1'b0, 8'h0c, 0);
      if (rd[0] === 1'b0) break;
    end
    chk(rd[0], 32'h0);
    repeat (12 * div) @(posedge clk_i);
    chk({lclk, txd}, 32'h1);
    chk(last, ch);
    chk(nnul, exp);
    $display("test char %h done", ch[7:0]);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      $display("unexpected at %0t: run too long", $time);
      results;
    end
  end
  // ****************************************************
  // tests
  // ****************************************************
  initial begin
    nrst_i = 1'b0;
    hsel = 1'b1;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    div = 12'h00a;
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    xfer(1'b0, 8'h00, 0);
    chk(rd, 32'h0000_0020);
    xfer(1'b0, 8'h0c, 0);
    chk(rd, 32'h0000_0000);
    xfer(1'b0, 8'h40, 0);
    chk(rd, 32'h0000_0000);
    chk(hresp, 32'h0);
    $display("test reset done");
    send(0, 0, 2, 0, 1, 8'h41, 1);
    send(0, 0, 2, 0, 0, 8'h42, 0);
    for (int i = 0; i < 6; i++) send(1, i, 1, 0, 2, 8'h43, 5 * fv[i] / 1000);
    send(1, 0, 1, 3, 3, 8'h44, 3 * 1330 / 1000);
    send(1, 0, 1, 500, 4, 8'h45, 500 * 1330 / 260000);
    send(1, 0, 1, 400, 6, 8'h46, 400 * 1330 / 260000);
    send(1, 0, 1, 300, 5, 8'h47, 300 * 1330 / 260000);
    send(1, 0, 1, 9, 7, 8'h48, 9 * 1330 / 1000);
    send(1, 0, 1, 0, 1, 8'h49, 1);
    send(1, 0, 1, 0, 0, 8'h0d, 0);
    send(2, 0, 1, 1000, 5, 8'h4a, 1000 * 1330 / 260000);
    send(2, 0, 1, 1000, 4, 8'h4b, 0);
    send(2, 0, 1, 0, 1, 8'h4c, 1);
    xfer(1'b1, 8'h00, 32'h0000_0008);
    xfer(1'b1, 8'h08, 32'h0000_004d);
    xfer(1'b0, 8'h0c, 0);
    chk(rd[2:0], 32'h4);
    $display("test refused config done");
    xfer(1'b1, 8'h0c, 32'h0000_0004);
    xfer(1'b1, 8'h00, 32'h0000_0000);
    xfer(1'b0, 8'h00, 0);
    chk(rd, 32'h0000_0000);
    xfer(1'b1, 8'h00, 32'h0000_0020);
    xfer(1'b1, 8'h08, 32'h0000_014e);
    xfer(1'b1, 8'h08, 32'h0000_004f);
    xfer(1'b0, 8'h0c, 0);
    chk(rd[2:0], 32'h3);
    $display("test overrun done");
    results;
  end
endmodule
